//--- verilog/osc_select_autocal_sqw.sv
// Oscillator select, RC autocalibration and square-wave output of the clock device
module osc_select_autocal_sqw
  import osc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Register access
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // Oscillator ticks
  input  wire logic       crystal_tick_i,
  input  wire logic       rc_tick_i,
  // Pin and status
  output logic            square_wave_pin_o,
  output logic            osc_source_select_o,
  output logic            cal_busy_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0]     wave_ctl_q, wave_ctl_d;
  logic [7:0]     osc_ctl_q, osc_ctl_d;
  logic           key_q, key_d;
  logic [7:0]     trim_lo_q, trim_lo_d;
  logic [7:0]     trim_hi_q, trim_hi_d;
  logic [7:0]     rdata_q, rdata_d;
  logic [14:0]    div_q, div_d;
  logic           sec_q, sec_d;
  logic           pin_q, pin_d;
  osc_cal_state_t cal_state_q, cal_state_d;
  logic [15:0]    xt_cnt_q, xt_cnt_d;
  logic [16:0]    rc_cnt_q, rc_cnt_d;
  logic [8:0]     period_q, period_d;
  logic [5:0]     cal_sec_q, cal_sec_d;
  logic           store_q, store_d;
  logic [15:0]    cal_val_q, cal_val_d;
  logic           busy_q, busy_d;
  logic           wr_wave, wr_osc, wr_key, osc_wr_ok;
  logic           autocal_active, start_req, period_hit;
  logic           rc_adj_tick, base_tick, wave_sel;
  logic [16:0]    rc_final;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_wave   = reg_wr_i && (reg_addr_i == ADDR_WAVE_CTL);
  assign wr_osc    = reg_wr_i && (reg_addr_i == ADDR_OSC_CTL);
  assign wr_key    = reg_wr_i && (reg_addr_i == ADDR_CFG_KEY);
  assign osc_wr_ok = wr_osc && key_q;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  always_comb begin
    wave_ctl_d = wave_ctl_q;
    osc_ctl_d  = osc_ctl_q;
    key_d      = key_q;
    trim_lo_d  = trim_lo_q;
    trim_hi_d  = trim_hi_q;
    rdata_d    = rdata_q;
    if (wr_wave) begin
      wave_ctl_d = {reg_wdata_i[WAVE_EN_BIT], 2'b00, reg_wdata_i[FREQ_HI:FREQ_LO]};
    end
    if (wr_key) begin
      key_d = (reg_wdata_i == CFG_KEY_VALUE);
    end else if (osc_wr_ok) begin
      key_d = 1'b0;
    end
    if (osc_wr_ok) begin
      osc_ctl_d = reg_wdata_i;
    end
    // A finishing calibration wins over a host write in the same cycle
    if (store_q) begin
      trim_lo_d = cal_val_q[7:0];
      trim_hi_d = cal_val_q[15:8];
    end else begin
      if (reg_wr_i && (reg_addr_i == ADDR_TRIM_LO)) begin
        trim_lo_d = reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == ADDR_TRIM_HI)) begin
        trim_hi_d = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_addr_i == ADDR_WAVE_CTL) begin
        rdata_d = wave_ctl_q;
      end else if (reg_addr_i == ADDR_TRIM_LO) begin
        rdata_d = trim_lo_q;
      end else if (reg_addr_i == ADDR_TRIM_HI) begin
        rdata_d = trim_hi_q;
      end else if (reg_addr_i == ADDR_OSC_CTL) begin
        rdata_d = osc_ctl_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wave_ctl_q <= WAVE_CTL_RST;
      osc_ctl_q  <= OSC_CTL_RST;
      key_q      <= 1'b0;
      trim_lo_q  <= TRIM_RST;
      trim_hi_q  <= TRIM_RST;
      rdata_q    <= 8'h00;
    end else begin
      wave_ctl_q <= wave_ctl_d;
      osc_ctl_q  <= osc_ctl_d;
      key_q      <= key_d;
      trim_lo_q  <= trim_lo_d;
      trim_hi_q  <= trim_hi_d;
      rdata_q    <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Timebase and square wave
  // ----------------------------------------------------------------
  osc_trim_adjust u_trim_adjust (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .rc_tick_i (rc_tick_i),
    .reload_i  (sec_q),
    .trim_i    ({trim_hi_q, trim_lo_q}),
    .tick_o    (rc_adj_tick)
  );

  assign base_tick = osc_ctl_q[OSC_SRC_BIT] ? rc_adj_tick : crystal_tick_i;

  always_comb begin
    wave_sel = 1'b0;
    if (wave_ctl_q[FREQ_HI]) begin
      wave_sel = 1'b0;
    end else if (wave_ctl_q[3:0] == 4'h0) begin
      wave_sel = div_q[0];
    end else begin
      wave_sel = div_q[4'(wave_ctl_q[3:0] - 4'h1)];
    end
  end

  always_comb begin
    div_d = 15'(div_q + {14'h0000, base_tick});
    sec_d = base_tick && (div_q == DIV_LAST);
    pin_d = wave_ctl_q[WAVE_EN_BIT] ? wave_sel : pin_q;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 15'h0000;
      sec_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      div_q <= div_d;
      sec_q <= sec_d;
      pin_q <= pin_d;
    end
  end

  // ----------------------------------------------------------------
  // Autocalibration
  // ----------------------------------------------------------------
  assign autocal_active = osc_ctl_q[OSC_SRC_BIT] &&
                          (osc_ctl_q[AUTOCAL_HI:AUTOCAL_LO] == AUTOCAL_ON);
  assign start_req  = osc_wr_ok && reg_wdata_i[OSC_SRC_BIT] &&
                      (reg_wdata_i[AUTOCAL_HI:AUTOCAL_LO] == AUTOCAL_ON);
  assign period_hit = autocal_active && sec_q && (period_q == PERIOD_LAST);
  assign rc_final   = 17'(rc_cnt_q + {16'h0000, rc_tick_i});

  always_comb begin
    cal_state_d = cal_state_q;
    xt_cnt_d    = xt_cnt_q;
    rc_cnt_d    = rc_cnt_q;
    cal_sec_d   = cal_sec_q;
    store_d     = 1'b0;
    cal_val_d   = cal_val_q;
    if (start_req || !autocal_active) begin
      period_d = 9'h000;
    end else begin
      period_d = 9'(period_q + {8'h00, sec_q});
    end
    case (cal_state_q)
      CAL_IDLE: begin
        if (start_req || period_hit) begin
          cal_state_d = CAL_MEASURE;
          xt_cnt_d    = 16'h0000;
          rc_cnt_d    = 17'h00000;
          cal_sec_d   = 6'h00;
        end
      end
      CAL_MEASURE: begin
        xt_cnt_d  = 16'(xt_cnt_q + {15'h0000, crystal_tick_i});
        rc_cnt_d  = rc_final;
        cal_sec_d = 6'(cal_sec_q + {5'h00, sec_q});
        if (!autocal_active) begin
          cal_state_d = CAL_IDLE;
        end else if ((crystal_tick_i && (xt_cnt_q == 16'(TICKS_PER_S - 16'h0001))) ||
                     (sec_q && (cal_sec_q == CAL_SEC_LAST))) begin
          // RC ticks counted over one crystal second, or over 60 timebase seconds at the limit, less the nominal count
          cal_state_d = CAL_IDLE;
          store_d     = 1'b1;
          cal_val_d   = 16'(rc_final - {1'b0, TICKS_PER_S});
        end
      end
      default: begin
        cal_state_d = CAL_IDLE;
      end
    endcase
    busy_d = (cal_state_d == CAL_MEASURE);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cal_state_q <= CAL_IDLE;
      xt_cnt_q    <= 16'h0000;
      rc_cnt_q    <= 17'h00000;
      period_q    <= 9'h000;
      cal_sec_q   <= 6'h00;
      store_q     <= 1'b0;
      cal_val_q   <= 16'h0000;
      busy_q      <= 1'b0;
    end else begin
      cal_state_q <= cal_state_d;
      xt_cnt_q    <= xt_cnt_d;
      rc_cnt_q    <= rc_cnt_d;
      period_q    <= period_d;
      cal_sec_q   <= cal_sec_d;
      store_q     <= store_d;
      cal_val_q   <= cal_val_d;
      busy_q      <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o         = rdata_q;
  assign square_wave_pin_o   = pin_q;
  assign osc_source_select_o = osc_ctl_q[OSC_SRC_BIT];
  assign cal_busy_o          = busy_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_WAVE_STATIC: assert property (!wave_ctl_q[WAVE_EN_BIT] |=> $stable(square_wave_pin_o))
    else $error("pin moved while wave disabled");
  AST_WAVE_1HZ: assert property ((wave_ctl_q == 8'h8f) |=> square_wave_pin_o == $past(div_q[14]))
    else $error("1 Hz code not on divider bit 14");
  AST_PIN_CAUSE: assert property ($changed(square_wave_pin_o) |-> $past(wave_ctl_q[WAVE_EN_BIT]))
    else $error("pin changed with generator off");
  AST_SRC_XT: assert property (!osc_source_select_o && crystal_tick_i && div_q != DIV_LAST
    |=> div_q == $past(div_q) + 15'h0001)
    else $error("crystal tick not counted");
  AST_KEY_GUARD: assert property (wr_osc && !key_q |=> $stable(osc_ctl_q))
    else $error("oscillator control changed without key");
  AST_KEY_ONCE: assert property (wr_osc && key_q && !wr_key |=> !key_q ##1 $stable(osc_ctl_q) || key_q)
    else $error("key survived a protected write");
  AST_PERIOD_START: assert property (period_hit && cal_state_q == CAL_IDLE |=> cal_busy_o)
    else $error("512 s calibration not started");
  AST_START_NOW: assert property (start_req && cal_state_q == CAL_IDLE |=> cal_busy_o)
    else $error("calibration did not start at once");
  AST_CAL_BOUND: assert property (cal_state_q == CAL_MEASURE |-> cal_sec_q <= CAL_SEC_LAST)
    else $error("calibration ran past 60 s");
  AST_STORE: assert property (store_q |=> {trim_hi_q, trim_lo_q} == $past(cal_val_q))
    else $error("trim not stored after calibration");

  COV_KEYED_WRITE: cover property (wr_key ##[1:4] osc_wr_ok);
  COV_CAL_DONE:    cover property (cal_busy_o ##1 store_q);
  COV_WAVE_TOGGLE: cover property (wave_ctl_q[WAVE_EN_BIT] && $changed(square_wave_pin_o));

endmodule

//--- verilog/osc_pkg.sv
// Constants shared by the oscillator select, autocalibration and square-wave block
package osc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_WAVE_CTL = 8'h13;
  localparam logic [7:0] ADDR_TRIM_LO  = 8'h15;
  localparam logic [7:0] ADDR_TRIM_HI  = 8'h16;
  localparam logic [7:0] ADDR_OSC_CTL  = 8'h1c;
  localparam logic [7:0] ADDR_CFG_KEY  = 8'h1f;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int         WAVE_EN_BIT   = 7;
  localparam int         FREQ_HI       = 4;
  localparam int         FREQ_LO       = 0;
  localparam logic [4:0] FREQ_1HZ      = 5'h0f;
  localparam int         OSC_SRC_BIT   = 7;
  localparam int         AUTOCAL_HI    = 6;
  localparam int         AUTOCAL_LO    = 5;
  localparam logic [1:0] AUTOCAL_ON    = 2'h3;
  localparam logic [7:0] CFG_KEY_VALUE = 8'ha1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] WAVE_CTL_RST  = 8'h00;
  localparam logic [7:0] OSC_CTL_RST   = 8'h00;
  localparam logic [7:0] TRIM_RST      = 8'h00;

  // ----------------------------------------------------------------
  // Timing, counted in oscillator ticks and timebase seconds
  // ----------------------------------------------------------------
  localparam logic [14:0] DIV_LAST        = 15'h7fff;
  localparam logic [15:0] TICKS_PER_S     = 16'h8000;
  localparam int          AUTOCAL_PERIOD_S = 512;
  localparam logic [8:0]  PERIOD_LAST     = 9'(AUTOCAL_PERIOD_S - 1);
  localparam int          CAL_LIMIT_S     = 60;
  localparam logic [5:0]  CAL_SEC_LAST    = 6'(CAL_LIMIT_S - 1);

  typedef enum logic {CAL_IDLE, CAL_MEASURE} osc_cal_state_t;

endpackage

//--- verilog/osc_trim_adjust.sv
// Trim adjuster: drops or inserts RC ticks so the long-term rate is corrected
module osc_trim_adjust (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Raw tick and trim
  input  wire logic        rc_tick_i,
  input  wire logic        reload_i,
  input  wire logic [15:0] trim_i,
  // Corrected tick
  output logic             tick_o
);

  logic [15:0] budget_q, budget_d;
  logic        fast_q, fast_d;
  logic        tick_q, tick_d;

  // ----------------------------------------------------------------
  // Per-second correction budget
  // ----------------------------------------------------------------
  always_comb begin
    budget_d = budget_q;
    fast_d   = fast_q;
    tick_d   = rc_tick_i;
    if (reload_i) begin
      fast_d   = !trim_i[15];
      budget_d = trim_i[15] ? 16'(~trim_i + 16'h0001) : trim_i;
    end else if (budget_q != 16'h0000) begin
      // Corrections bunch at the start of a second: short-term jitter, exact average
      if (fast_q && rc_tick_i) begin
        tick_d   = 1'b0;
        budget_d = 16'(budget_q - 16'h0001);
      end else if (!fast_q && !rc_tick_i) begin
        tick_d   = 1'b1;
        budget_d = 16'(budget_q - 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      budget_q <= 16'h0000;
      fast_q   <= 1'b0;
      tick_q   <= 1'b0;
    end else begin
      budget_q <= budget_d;
      fast_q   <= fast_d;
      tick_q   <= tick_d;
    end
  end

  assign tick_o = tick_q;

  AST_TRIM_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
    (!reload_i && fast_q && budget_q != 16'h0000 && rc_tick_i) |=> !tick_o)
    else $error("fast RC tick was not dropped");

endmodule

//--- verif/osc_host_model.sv
// Host controller model issuing register writes and reads to the oscillator block
module osc_host_model
  import osc_pkg::*;
(
  // Clock
  input  wire logic       clk_i,
  // Register access
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
    reg_addr_o  = 8'h00;
    reg_wdata_o = 8'h00;
  end

  // Idle gap of zero to two cycles gives prompt and slow hosts
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat ($urandom_range(2, 0)) @(posedge clk_i);
    @(posedge clk_i);
    reg_wr_o    <= 1'b1;
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_addr_o  <= ~a;
    reg_wdata_o <= ~d;
  endtask

  // Data is taken at the edge after the read is accepted
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_rd_o   <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    reg_addr_o <= ~a;
    @(posedge clk_i);
    d = reg_rdata_i;
  endtask

  task automatic keyed_wr(input logic [7:0] d);
    wr(ADDR_CFG_KEY, CFG_KEY_VALUE);
    wr(ADDR_OSC_CTL, d);
  endtask
endmodule

//--- verif/testbench.sv
// Self-checking bench for the oscillator select, autocalibration and square-wave block
module testbench
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAX_CYCLES = 95000;

  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       crystal_tick = 1'b0;
  logic       rc_tick = 1'b0;
  logic       pin;
  logic       osc_src;
  logic       cal_busy;
  int         mismatches = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         hp;
  int         code;
  logic [7:0] v;
  logic [7:0] d;
  int         trim_exp;

  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Oscillator ticks: crystal every cycle, raw RC three of four
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles       <= cycles + 1;
    crystal_tick <= 1'b1;
    rc_tick      <= (cycles % 4) != 3;
    if (cycles == MAX_CYCLES) begin
      mismatches++;
      tally_and_finish();
    end
  end

  osc_host_model u_osc_host_model (
    .clk_i       (clk_i),
    .reg_wr_o    (reg_wr),
    .reg_rd_o    (reg_rd),
    .reg_addr_o  (reg_addr),
    .reg_wdata_o (reg_wdata),
    .reg_rdata_i (reg_rdata)
  );

  osc_select_autocal_sqw u_osc_select_autocal_sqw (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .reg_wr_i            (reg_wr),
    .reg_rd_i            (reg_rd),
    .reg_addr_i          (reg_addr),
    .reg_wdata_i         (reg_wdata),
    .reg_rdata_o         (reg_rdata),
    .crystal_tick_i      (crystal_tick),
    .rc_tick_i           (rc_tick),
    .square_wave_pin_o   (pin),
    .osc_source_select_o (osc_src),
    .cal_busy_o          (cal_busy)
  );

  // ----------------------------------------------------------------
  // Expectations and helpers
  // ----------------------------------------------------------------
  function automatic int exp_half(input int k);
    return 1 << (k - 1);
  endfunction

  function automatic logic [15:0] exp_trim(input int raw);
    return 16'(raw - 32768);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Waits for a pin change, then counts cycles to the next change
  task automatic half_period(output int n);
    logic p;
    n = 0;
    p = pin;
    for (int i = 0; i < 40000 && pin === p; i++) @(posedge clk_i);
    p = pin;
    while (n < 40000 && pin === p) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic wave_code(input logic [7:0] val);
    u_osc_host_model.wr(ADDR_WAVE_CTL, val);
    repeat (4) @(posedge clk_i);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(58709));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);

    u_osc_host_model.wr(ADDR_WAVE_CTL, 8'hff);
    u_osc_host_model.rd(ADDR_WAVE_CTL, d);
    chk(d, 8'h9f, "wave control readback");
    for (int i = 0; i < 4; i++) begin
      code = $urandom_range(8, 1);
      wave_code(8'h80 | 8'(code));
      half_period(hp);
      chk(16'(hp), 16'(exp_half(code)), "half period");
    end
    // Code zero runs at the same rate as code one
    wave_code(8'h80);
    half_period(hp);
    chk(16'(hp), 16'h0001, "code zero half period");
    wave_code(8'h01);
    v = pin;
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      chk(pin, v, "frozen pin");
    end
    wave_code(8'h80 | 8'($urandom_range(31, 16)));
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      chk(pin, 1'b0, "reserved code pin");
    end
    wave_code(8'h8f);
    half_period(hp);
    chk(16'(hp), 16'(exp_half(15)), "one hertz half period");
    $display("test square wave done");

    v = 8'h20 + 8'($urandom_range(223, 0));
    u_osc_host_model.wr(v, 8'($urandom));
    u_osc_host_model.rd(v, d);
    chk(d, 8'h00, "unmapped read");
    u_osc_host_model.rd(ADDR_CFG_KEY, d);
    chk(d, 8'h00, "key read");
    for (int i = 0; i < 2; i++) begin
      v = 8'($urandom);
      u_osc_host_model.wr(i == 0 ? ADDR_TRIM_LO : ADDR_TRIM_HI, v);
      u_osc_host_model.rd(i == 0 ? ADDR_TRIM_LO : ADDR_TRIM_HI, d);
      chk(d, v, "trim readback");
    end
    $display("test registers done");

    u_osc_host_model.wr(ADDR_OSC_CTL, 8'h80);
    #1 chk(osc_src, 1'b0, "unkeyed write ignored");
    u_osc_host_model.wr(ADDR_CFG_KEY, CFG_KEY_VALUE);
    u_osc_host_model.wr(ADDR_WAVE_CTL, 8'h00);
    u_osc_host_model.wr(ADDR_OSC_CTL, 8'h80);
    #1 chk(osc_src, 1'b1, "rc selected");
    u_osc_host_model.wr(ADDR_OSC_CTL, 8'h00);
    u_osc_host_model.rd(ADDR_OSC_CTL, d);
    chk(d, 8'h80, "key spent");
    u_osc_host_model.wr(ADDR_CFG_KEY, CFG_KEY_VALUE);
    u_osc_host_model.wr(ADDR_CFG_KEY, 8'h55);
    u_osc_host_model.wr(ADDR_OSC_CTL, 8'h00);
    #1 chk(osc_src, 1'b1, "key cleared by other value");
    u_osc_host_model.keyed_wr(8'h00);
    #1 chk(osc_src, 1'b0, "crystal selected");
    $display("test key and source done");

    u_osc_host_model.keyed_wr(8'he0);
    #1 chk(cal_busy, 1'b1, "calibration starts at once");
    for (int i = 0; i < 40000 && cal_busy === 1'b1; i++) @(posedge clk_i);
    chk(cal_busy, 1'b0, "calibration finished");
    repeat (4) @(posedge clk_i);
    // Three raw RC ticks in four cycles over one crystal second
    trim_exp = exp_trim(24576);
    u_osc_host_model.rd(ADDR_TRIM_LO, d);
    chk(d, trim_exp[7:0], "trim low byte");
    u_osc_host_model.rd(ADDR_TRIM_HI, d);
    chk(d, trim_exp[15:8], "trim high byte");
    // Field value two stops a running measurement without a store
    u_osc_host_model.keyed_wr(8'he0);
    u_osc_host_model.keyed_wr(8'hc0);
    @(posedge clk_i);
    #1 chk(cal_busy, 1'b0, "field two aborts calibration");
    u_osc_host_model.rd(ADDR_TRIM_HI, d);
    chk(d, trim_exp[15:8], "trim kept after abort");
    $display("test calibration done");
    tally_and_finish();
  end
endmodule
